/* File: rtl/pfh_regs.vh */
/*
 fault handling unit constants: register byte offsets, field positions, reset values.
 assumes word-aligned AHB-Lite access with 32-bit data.
*/
`ifndef PFH_REGS_VH
`define PFH_REGS_VH
// register byte offsets
`define PFH_TOP_FAULT_STATUS 12'h000
`define PFH_PROTECTION_FAULT_STATUS 12'h004
`define PFH_PROTECTION_FAULT_ADDRESS 12'h008
`define PFH_BUS_ERROR_STATUS 12'h00c
`define PFH_BUS_ERROR_ADDRESS 12'h010
`define PFH_USAGE_ERROR_STATUS 12'h014
`define PFH_HANDLER_CTRL 12'h018
`define PFH_CORE_STATE 12'h01c
// top fault status fields
`define PFH_VECT_BIT 1
`define PFH_ESC_BIT 30
// protection fault status fields
`define PFH_IACC_BIT 0
`define PFH_DACC_BIT 1
`define PFH_MUNSTK_BIT 3
`define PFH_MSTK_BIT 4
`define PFH_MLSP_BIT 5
`define PFH_MVALID_BIT 7
// bus error status fields
`define PFH_IBUS_BIT 0
`define PFH_PREC_BIT 1
`define PFH_IMPREC_BIT 2
`define PFH_BUNSTK_BIT 3
`define PFH_BSTK_BIT 4
`define PFH_BLSP_BIT 5
`define PFH_BVALID_BIT 7
// usage error status fields
`define PFH_COPROCESSOR_ABSENT_FLAG_BIT 3
`define PFH_UNDEF_BIT 0
`define PFH_STATE_BIT 1
`define PFH_RETV_BIT 2
`define PFH_UNAL_BIT 8
`define PFH_DIV0_BIT 9
// handler control fields: enables [2:0], priorities [15:8],[23:16],[31:24]
`define PFH_EN_MEM_BIT 0
`define PFH_EN_BUS_BIT 1
`define PFH_EN_USE_BIT 2
`define PFH_CTRL_RST 32'h0000_0000
// status and address register reset values
`define PFH_STAT_RST 32'h0000_0000
`define PFH_ADDR_RST 32'h0000_0000
// core state fields
`define PFH_LOCK_BIT 0
`define PFH_LOCKNMI_BIT 1
// return token top bits
`define PFH_RET_TOKEN_TOP 27'h7ff_ffff
`endif

/* File: rtl/pfh_fault_unit.v */
/*
 fault classification, escalation, address capture and lockup logic of the core.
 assumes fault reports are one-cycle pulses synchronous to clk, and an AHB-Lite
 master for register access. single-cycle OKAY slave.
*/
// Operation
// - raise faults for bus, opcode, exec, protection
// - vector read error goes top, sets flag
// - escalated fault sets escalation flag
// - protection mismatch sets matching protection flag
// - no-execute fetch faults even without protection
// - bus error sets matching bus flag
// - usage fault sets matching usage flag
// - bad instruction set or continuation is bad state
// - configurable priority and enable per handler
// - escalate on same, lower priority, or disabled
// - bus fault stacking own handler never escalates
// - top fault preempts all but reset, nmi
// - loads sync, stores async, debugger sync only
// - async bus error pends bus or top, no lockup
// - async error may land after context change
// - sync bus error in nmi/top handler locks up
// - cache maintenance reports bus errors too
// - capture address for sync bus, protection data faults
// - sync fault or vector read error in nmi or top handler locks up
// - leave lockup on reset, debug halt, or nmi unless lockup was entered from nmi
// - return token needs bits 31..5 all ones
`include "pfh_regs.vh"
`default_nettype none
module pfh_fault_unit (
  // clock and reset
  input wire clk,
  input wire srst,
  // ahb-lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // fault reports from bus, protection unit and decoder (one-cycle pulses)
  input wire bus_err,
  input wire [31:0] bus_err_addr,
  input wire bus_err_store,
  input wire bus_err_debug,
  input wire bus_err_vector,
  input wire bus_err_fetch,
  input wire bus_err_cache,
  input wire prot_err,
  input wire [31:0] prot_err_addr,
  input wire prot_err_fetch,
  input wire no_execute_fetch,
  input wire undef_opcode,
  input wire coproc_access,
  input wire unaligned_access,
  input wire divide_by_zero,
  input wire bad_isa_select,
  input wire continuation_return_bad,
  input wire return_load,
  input wire [31:0] return_value,
  // access phase: 0 normal, 1 stacking, 2 unstacking, 3 lazy fp
  input wire [1:0] access_phase,
  // executing context
  input wire [7:0] cur_priority,
  input wire [1:0] cur_fault_kind,
  input wire in_handler,
  input wire in_nmi,
  input wire in_top_fault,
  input wire entering_bus_handler,
  input wire nmi_req,
  input wire debug_halt,
  // results
  output reg mem_pend_q,
  output reg bus_pend_q,
  output reg use_pend_q,
  output reg top_pend_q,
  output reg lockup_q,
  output reg debug_bus_err_q
);
  // fault kinds
  localparam [1:0] KIND_NONE = 2'h0;
  localparam [1:0] KIND_MEM = 2'h1;
  localparam [1:0] KIND_BUS = 2'h2;
  localparam [1:0] KIND_USE = 2'h3;
  localparam [1:0] PH_STACK = 2'h1;
  localparam [1:0] PH_UNSTACK = 2'h2;
  localparam [1:0] PH_LAZY = 2'h3;

  reg [31:0] top_stat_q;
  reg [31:0] mem_stat_q;
  reg [31:0] bus_stat_q;
  reg [31:0] use_stat_q;
  reg [31:0] mem_addr_q;
  reg [31:0] bus_addr_q;
  reg [31:0] ctrl_q;
  reg lock_nmi_q;
  reg [31:0] rdata_q;
  reg wr_pend_q;
  reg [11:0] wr_addr_q;

  // return token check
  wire bad_return = return_load & in_handler & (return_value[31:5] != `PFH_RET_TOKEN_TOP);
  // core bus errors only; debugger errors stay on the debug port
  wire core_bus = bus_err & ~bus_err_debug;
  wire bus_vec = core_bus & bus_err_vector;
  wire bus_async = core_bus & bus_err_store & ~bus_err_vector;
  wire bus_sync = core_bus & ~bus_err_store & ~bus_err_vector;
  wire mem_ev = prot_err | no_execute_fetch;
  wire bad_state = bad_isa_select | continuation_return_bad;
  wire use_ev = undef_opcode | coproc_access | unaligned_access | divide_by_zero | bad_state | bad_return;
  // pick one new fault per cycle: protection, sync bus, usage, async bus; a vector error is taken alongside
  reg [1:0] kind;
  reg sync_ev;
  always @* begin
    kind = KIND_NONE;
    sync_ev = 1'b1;
    if (mem_ev) begin
      kind = KIND_MEM;
    end else if (bus_sync) begin
      kind = KIND_BUS;
    end else if (use_ev) begin
      kind = KIND_USE;
    end else if (bus_async) begin
      kind = KIND_BUS;
      sync_ev = 1'b0;
    end
  end

  // per-kind enable and priority
  reg kind_en;
  reg [7:0] kind_pri;
  always @* begin
    case (kind)
      KIND_MEM: begin
        kind_en = ctrl_q[`PFH_EN_MEM_BIT];
        kind_pri = ctrl_q[15:8];
      end
      KIND_BUS: begin
        kind_en = ctrl_q[`PFH_EN_BUS_BIT];
        kind_pri = ctrl_q[23:16];
      end
      KIND_USE: begin
        kind_en = ctrl_q[`PFH_EN_USE_BIT];
        kind_pri = ctrl_q[31:24];
      end
      default: begin
        kind_en = 1'b0;
        kind_pri = 8'hff;
      end
    endcase
  end

  wire in_crit = in_nmi | in_top_fault;
  wire stack_own = (kind == KIND_BUS) & sync_ev & entering_bus_handler & (access_phase == PH_STACK);
  // lower numeric value is higher priority; equal or lower priority cannot preempt
  wire same_kind = in_handler & (cur_fault_kind == kind);
  wire no_preempt = in_handler & (kind_pri >= cur_priority);
  wire escalate = (kind != KIND_NONE) & ~stack_own & ~in_crit & (~kind_en | same_kind | no_preempt);
  // async bus errors escalate only by disabled handler and never lock up
  wire esc_eff = sync_ev ? escalate : ((kind == KIND_BUS) & ~kind_en);
  wire go_lock = in_crit & ((kind != KIND_NONE) & sync_ev | bus_vec);

  // bus slave: zero wait, always OKAY
  wire take = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  wire wr_now = wr_pend_q;
  wire clr_top = wr_now & (wr_addr_q == `PFH_TOP_FAULT_STATUS);
  wire clr_mem = wr_now & (wr_addr_q == `PFH_PROTECTION_FAULT_STATUS);
  wire clr_bus = wr_now & (wr_addr_q == `PFH_BUS_ERROR_STATUS);
  wire clr_use = wr_now & (wr_addr_q == `PFH_USAGE_ERROR_STATUS);

  // set bits this cycle
  reg [31:0] top_set;
  reg [31:0] mem_set;
  reg [31:0] bus_set;
  reg [31:0] use_set;
  always @* begin
    top_set = 32'h0;
    mem_set = 32'h0;
    bus_set = 32'h0;
    use_set = 32'h0;
    top_set[`PFH_VECT_BIT] = bus_vec;
    top_set[`PFH_ESC_BIT] = esc_eff & ~go_lock;
    if (kind == KIND_MEM) begin
      if (access_phase == PH_STACK) begin
        mem_set[`PFH_MSTK_BIT] = 1'b1;
      end else if (access_phase == PH_UNSTACK) begin
        mem_set[`PFH_MUNSTK_BIT] = 1'b1;
      end else if (access_phase == PH_LAZY) begin
        mem_set[`PFH_MLSP_BIT] = 1'b1;
      end else if (prot_err_fetch | no_execute_fetch) begin
        mem_set[`PFH_IACC_BIT] = 1'b1;
      end else begin
        mem_set[`PFH_DACC_BIT] = 1'b1;
        mem_set[`PFH_MVALID_BIT] = 1'b1;
      end
    end
    if (kind == KIND_BUS) begin
      if (~sync_ev) begin
        bus_set[`PFH_IMPREC_BIT] = 1'b1;
      end else if (access_phase == PH_STACK) begin
        bus_set[`PFH_BSTK_BIT] = 1'b1;
      end else if (access_phase == PH_UNSTACK) begin
        bus_set[`PFH_BUNSTK_BIT] = 1'b1;
      end else if (access_phase == PH_LAZY) begin
        bus_set[`PFH_BLSP_BIT] = 1'b1;
      end else if (bus_err_fetch) begin
        bus_set[`PFH_IBUS_BIT] = 1'b1;
      end else begin
        bus_set[`PFH_PREC_BIT] = 1'b1;
        bus_set[`PFH_BVALID_BIT] = 1'b1;
      end
    end
    if (kind == KIND_USE) begin
      use_set[`PFH_COPROCESSOR_ABSENT_FLAG_BIT] = coproc_access;
      use_set[`PFH_UNDEF_BIT] = undef_opcode;
      use_set[`PFH_STATE_BIT] = bad_state;
      use_set[`PFH_RETV_BIT] = bad_return;
      use_set[`PFH_UNAL_BIT] = unaligned_access;
      use_set[`PFH_DIV0_BIT] = divide_by_zero;
    end
  end

  // write data clears its one bits in the status register it addresses
  wire [31:0] top_clr = clr_top ? hwdata : 32'h0;
  wire [31:0] mem_clr = clr_mem ? hwdata : 32'h0;
  wire [31:0] bus_clr = clr_bus ? hwdata : 32'h0;
  wire [31:0] use_clr = clr_use ? hwdata : 32'h0;
  // next status; a set in the same cycle wins over a clear
  reg [31:0] top_stat_d;
  reg [31:0] mem_stat_d;
  reg [31:0] bus_stat_d;
  reg [31:0] use_stat_d;
  always @* begin
    top_stat_d = (top_stat_q & ~top_clr) | top_set;
    mem_stat_d = (mem_stat_q & ~mem_clr) | mem_set;
    bus_stat_d = (bus_stat_q & ~bus_clr) | bus_set;
    use_stat_d = (use_stat_q & ~use_clr) | use_set;
  end

  always @(posedge clk) begin
    if (srst) begin
      top_stat_q <= `PFH_STAT_RST;
      mem_stat_q <= `PFH_STAT_RST;
      bus_stat_q <= `PFH_STAT_RST;
      use_stat_q <= `PFH_STAT_RST;
    end else begin
      top_stat_q <= top_stat_d;
      mem_stat_q <= mem_stat_d;
      bus_stat_q <= bus_stat_d;
      use_stat_q <= use_stat_d;
    end
  end

  // address capture for synchronous data faults only
  reg [31:0] mem_addr_d;
  reg [31:0] bus_addr_d;
  always @* begin
    mem_addr_d = mem_set[`PFH_MVALID_BIT] ? prot_err_addr : mem_addr_q;
    bus_addr_d = bus_set[`PFH_BVALID_BIT] ? bus_err_addr : bus_addr_q;
  end

  always @(posedge clk) begin
    if (srst) begin
      mem_addr_q <= `PFH_ADDR_RST;
      bus_addr_q <= `PFH_ADDR_RST;
    end else begin
      mem_addr_q <= mem_addr_d;
      bus_addr_q <= bus_addr_d;
    end
  end

  // pending exceptions; top fault is fixed highest below reset and nmi
  always @(posedge clk) begin
    if (srst) begin
      mem_pend_q <= 1'b0;
      bus_pend_q <= 1'b0;
      use_pend_q <= 1'b0;
      top_pend_q <= 1'b0;
      debug_bus_err_q <= 1'b0;
    end else begin
      debug_bus_err_q <= bus_err & bus_err_debug;
      mem_pend_q <= (kind == KIND_MEM) & ~esc_eff & ~go_lock;
      bus_pend_q <= (kind == KIND_BUS) & ~esc_eff & ~go_lock;
      use_pend_q <= (kind == KIND_USE) & ~esc_eff & ~go_lock;
      top_pend_q <= (esc_eff | bus_vec) & ~go_lock & ~nmi_req;
    end
  end

  // lockup states
  localparam [1:0] LK_RUN = 2'h0;
  localparam [1:0] LK_FAULT = 2'h1;
  localparam [1:0] LK_NMI = 2'h2;
  reg [1:0] lk_state_q;
  reg [1:0] lk_state_d;
  always @* begin
    lk_state_d = lk_state_q;
    case (lk_state_q)
      LK_RUN: begin
        if (go_lock) begin
          lk_state_d = in_nmi ? LK_NMI : LK_FAULT;
        end
      end
      LK_FAULT: begin
        if (debug_halt | nmi_req) begin
          lk_state_d = LK_RUN;
        end
      end
      LK_NMI: begin
        // a later nmi cannot free a lockup entered from the nmi handler
        if (debug_halt) begin
          lk_state_d = LK_RUN;
        end
      end
      default: begin
        lk_state_d = LK_RUN;
      end
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      lk_state_q <= LK_RUN;
      lockup_q <= 1'b0;
      lock_nmi_q <= 1'b0;
    end else begin
      lk_state_q <= lk_state_d;
      lockup_q <= (lk_state_d != LK_RUN);
      lock_nmi_q <= (lk_state_d == LK_NMI);
    end
  end

  // read mux; the data phase flop takes it only when a read is accepted
  reg [31:0] rdata_d;
  always @* begin
    rdata_d = rdata_q;
    if (take & ~hwrite) begin
      case ({haddr[11:2], 2'b00})
        `PFH_TOP_FAULT_STATUS: rdata_d = top_stat_q;
        `PFH_PROTECTION_FAULT_STATUS: rdata_d = mem_stat_q;
        `PFH_PROTECTION_FAULT_ADDRESS: rdata_d = mem_addr_q;
        `PFH_BUS_ERROR_STATUS: rdata_d = bus_stat_q;
        `PFH_BUS_ERROR_ADDRESS: rdata_d = bus_addr_q;
        `PFH_USAGE_ERROR_STATUS: rdata_d = use_stat_q;
        `PFH_HANDLER_CTRL: rdata_d = ctrl_q;
        `PFH_CORE_STATE: rdata_d = {30'h0, lock_nmi_q, lockup_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // register access
  always @(posedge clk) begin
    if (srst) begin
      ctrl_q <= `PFH_CTRL_RST;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h0;
      rdata_q <= 32'h0;
    end else begin
      wr_pend_q <= take & hwrite;
      wr_addr_q <= {haddr[11:2], 2'b00};
      if (wr_now & (wr_addr_q == `PFH_HANDLER_CTRL)) begin
        ctrl_q <= hwdata;
      end
      rdata_q <= rdata_d;
    end
  end
endmodule // pfh_fault_unit
`default_nettype wire

/* File: tb/pfh_assertions.sv */
/* fault unit port checker: lockup, escalation and pending outputs.
 assumes one-cycle fault pulses and registered outputs one edge later. */
`default_nettype none
module pfh_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // fault reports
  input wire logic bus_err,
  input wire logic bus_err_store,
  input wire logic bus_err_debug,
  input wire logic bus_err_vector,
  input wire logic prot_err,
  input wire logic no_execute_fetch,
  // context
  input wire logic in_handler,
  input wire logic in_nmi,
  input wire logic in_top_fault,
  input wire logic nmi_req,
  input wire logic debug_halt,
  // results
  input wire logic mem_pend_q,
  input wire logic bus_pend_q,
  input wire logic top_pend_q,
  input wire logic lockup_q,
  input wire logic debug_bus_err_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire quiet = !in_handler && !in_nmi && !in_top_fault && !nmi_req && !lockup_q;
  AST_XN_FAULT: assert property (no_execute_fetch && quiet |=> mem_pend_q || top_pend_q)
    else $error("no-execute fetch raised no fault");
  AST_TOP_LOCK: assert property (prot_err && (in_nmi || in_top_fault) && !nmi_req && !debug_halt
    |=> lockup_q && !top_pend_q && !mem_pend_q) else $error("fault in nmi or top handler did not lock");
  AST_SYNC_LOCK: assert property (bus_err && !bus_err_store && !bus_err_debug && (in_nmi || in_top_fault)
    && !nmi_req && !debug_halt |=> lockup_q) else $error("sync bus error in top handler did not lock");
  AST_LOCK_HOLD: assert property (lockup_q && !srst && !nmi_req && !debug_halt |=> lockup_q)
    else $error("lockup left without cause");
  AST_LOCK_EXIT: assert property ($fell(lockup_q) |-> $past(nmi_req) || $past(debug_halt) || $past(srst))
    else $error("lockup left without nmi, halt or reset");
  AST_LOCK_DBG: assert property (lockup_q && debug_halt && !prot_err && !bus_err |=> !lockup_q)
    else $error("debug halt did not leave lockup");
  AST_NO_LOCK: assert property (!lockup_q && !in_nmi && !in_top_fault |=> !lockup_q)
    else $error("lockup outside nmi or top handler");
  AST_VECTOR_TOP: assert property (bus_err && bus_err_vector && !bus_err_debug && quiet |=> top_pend_q)
    else $error("vector read error did not pend top fault");
  AST_DEBUG_ONLY: assert property (bus_err && bus_err_debug |=> debug_bus_err_q && !bus_pend_q)
    else $error("debugger bus error not kept to debugger");
  AST_NMI_FIRST: assert property (nmi_req |=> !top_pend_q)
    else $error("top fault pended over nmi");
  cover property ($rose(lockup_q));
  cover property (top_pend_q);
  cover property (bus_pend_q);
  cover property (debug_bus_err_q);
endmodule // pfh_assertions
bind pfh_fault_unit pfh_assertions u_chk (.clk, .srst, .bus_err, .bus_err_store, .bus_err_debug, .bus_err_vector,
  .prot_err, .no_execute_fetch, .in_handler, .in_nmi, .in_top_fault, .nmi_req, .debug_halt, .mem_pend_q,
  .bus_pend_q, .top_pend_q, .lockup_q, .debug_bus_err_q);
`default_nettype wire

/* File: tb/pfh_partner.sv */
/* far side model: bus fabric, protection unit and decoder fault reports.
 assumes the bench drives the executing context levels. */
`default_nettype none
module pfh_partner (
  // clock
  input wire logic clk,
  // report pulses with qualifiers, shared address
  output logic [15:0] rep,
  output logic [31:0] addr
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] PULSES = 16'hff41;
  initial begin
    rep = 16'h0000;
    addr = 32'h0000_0000;
  end
  // one report for one cycle; stale qualifiers and address are inverted
  task automatic ev(input logic [15:0] k, input logic [31:0] a);
    @(posedge clk);
    rep <= k;
    addr <= a;
    @(posedge clk);
    rep <= ~k & ~PULSES;
    addr <= ~a;
  endtask
endmodule // pfh_partner
`default_nettype wire

/* File: tb/tb_top.sv */
/* fault unit bench: ahb-lite master, context levels, fault partner.
 assumes a zero-wait okay slave and one-cycle fault reports. */
`include "pfh_regs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, in_handler = 1'b0, in_nmi = 1'b0;
  logic in_top_fault = 1'b0, entering_bus_handler = 1'b0, nmi_req = 1'b0, debug_halt = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0, access_phase = 2'h0, cur_fault_kind = 2'h0;
  logic [7:0] cur_priority = 8'hff;
  logic [31:0] hwdata = 32'h0, rd;
  wire [31:0] hrdata, addr;
  wire [15:0] rep;
  wire hready, hresp, mem_pend_q, bus_pend_q, use_pend_q, top_pend_q, lockup_q, debug_bus_err_q;
  int n_fail = 0, checked = 0;
  always #25 clk = ~clk;
  pfh_partner u_part (.clk, .rep, .addr);
  pfh_fault_unit u_dut (.clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready, .hwdata, .hrdata,
    .hreadyout(hready), .hresp, .bus_err(rep[0]), .bus_err_addr(addr), .bus_err_store(rep[1]),
    .bus_err_debug(rep[2]), .bus_err_vector(rep[3]), .bus_err_fetch(rep[4]), .bus_err_cache(rep[5]),
    .prot_err(rep[6]), .prot_err_addr(addr), .prot_err_fetch(rep[7]), .no_execute_fetch(rep[8]),
    .undef_opcode(rep[9]), .coproc_access(rep[10]), .unaligned_access(rep[11]), .divide_by_zero(rep[12]),
    .bad_isa_select(rep[13]), .continuation_return_bad(rep[14]), .return_load(rep[15]), .return_value(addr),
    .access_phase, .cur_priority, .cur_fault_kind, .in_handler, .in_nmi, .in_top_fault, .entering_bus_handler,
    .nmi_req, .debug_halt, .mem_pend_q, .bus_pend_q, .use_pend_q, .top_pend_q, .lockup_q, .debug_bus_err_q);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report;
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", hresp, 0);
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask
  task automatic cx(input logic h, n, t, eb, input logic [1:0] k, ph, input logic [7:0] p);
    @(posedge clk);
    in_handler <= h;
    in_nmi <= n;
    in_top_fault <= t;
    entering_bus_handler <= eb;
    cur_fault_kind <= k;
    access_phase <= ph;
    cur_priority <= p;
  endtask
  task automatic s_regs;
    for (int i = 0; i < 9; i++) rdc("reset", 12'(i * 4), 0);
    bus(1'b1, 12'h020, 32'hffff_ffff);
    rdc("unmapped", 12'h020, 0);
    bus(1'b1, `PFH_HANDLER_CTRL, 32'h0302_0107);
    rdc("ctrl", `PFH_HANDLER_CTRL, 32'h0302_0107);
  endtask
  task automatic s_bus;
    cx(0, 0, 0, 0, 2'h0, 2'h1, 8'hff);
    u_part.ev(16'h0001, 32'h2000_0010);
    cx(0, 0, 0, 0, 2'h0, 2'h0, 8'hff);
    u_part.ev(16'h0001, 32'h2000_0020);
    #1 chk("bus_pend", bus_pend_q, 1);
    rdc("bus_stat", `PFH_BUS_ERROR_STATUS, 32'h0000_0092);
    rdc("bus_addr", `PFH_BUS_ERROR_ADDRESS, 32'h2000_0020);
    bus(1'b1, `PFH_BUS_ERROR_STATUS, 32'hffff_ffff);
    u_part.ev(16'h0003, 32'h2000_0030);
    u_part.ev(16'h0005, 32'h2000_0034);
    #1 chk("dbg_err", debug_bus_err_q, 1);
    rdc("async_stat", `PFH_BUS_ERROR_STATUS, 32'h0000_0004);
    u_part.ev(16'h0021, 32'h2000_0038);
    #1 chk("cache_pend", bus_pend_q, 1);
    cx(1, 0, 0, 1, 2'h2, 2'h1, 8'h00);
    u_part.ev(16'h0001, 32'h2000_003c);
    #1 chk("stk_pend", {top_pend_q, bus_pend_q}, 1);
    cx(0, 0, 0, 0, 2'h0, 2'h0, 8'hff);
  endtask
  task automatic s_top;
    u_part.ev(16'h0009, 32'h0000_0008);
    #1 chk("vec_pend", top_pend_q, 1);
    rdc("top_stat", `PFH_TOP_FAULT_STATUS, 32'h0000_0002);
    bus(1'b1, `PFH_HANDLER_CTRL, 32'h0302_0105);
    u_part.ev(16'h0003, 32'h2000_0040);
    #1 chk("async_top", top_pend_q, 1);
    cx(0, 0, 1, 0, 2'h0, 2'h0, 8'hff);
    u_part.ev(16'h0003, 32'h2000_0044);
    #1 chk("async_lock", lockup_q, 0);
    cx(0, 0, 0, 0, 2'h0, 2'h0, 8'hff);
    nmi_req <= 1'b1;
    u_part.ev(16'h0009, 32'h0000_000c);
    #1 chk("nmi_first", top_pend_q, 0);
    @(posedge clk) nmi_req <= 1'b0;
    bus(1'b1, `PFH_HANDLER_CTRL, 32'h0302_0107);
    bus(1'b1, `PFH_TOP_FAULT_STATUS, 32'hffff_ffff);
  endtask
  task automatic s_prot;
    cx(0, 0, 0, 0, 2'h0, 2'h3, 8'hff);
    u_part.ev(16'h0040, 32'h3000_0000);
    cx(0, 0, 0, 0, 2'h0, 2'h0, 8'hff);
    u_part.ev(16'h0040, 32'h3000_0004);
    #1 chk("mem_pend", mem_pend_q, 1);
    rdc("mem_stat", `PFH_PROTECTION_FAULT_STATUS, 32'h0000_00a2);
    rdc("mem_addr", `PFH_PROTECTION_FAULT_ADDRESS, 32'h3000_0004);
    bus(1'b1, `PFH_PROTECTION_FAULT_STATUS, 32'hffff_ffff);
    bus(1'b1, `PFH_HANDLER_CTRL, 32'h0302_0106);
    u_part.ev(16'h0100, 32'h3000_0008);
    #1 chk("xn_top", top_pend_q, 1);
    bus(1'b0, `PFH_PROTECTION_FAULT_STATUS, 32'h0);
    chk("xn_flag", rd & 32'h1, 1);
    rdc("escalation_flag", `PFH_TOP_FAULT_STATUS, 32'h4000_0000);
    bus(1'b1, `PFH_TOP_FAULT_STATUS, 32'hffff_ffff);
    bus(1'b1, `PFH_HANDLER_CTRL, 32'h0302_0107);
  endtask
  task automatic s_use;
    logic [15:0] ks [7] = '{16'h0200, 16'h2000, 16'h4000, 16'h8000, 16'h0400, 16'h0800, 16'h1000};
    int bs [7] = '{0, 1, 1, 2, 3, 8, 9};
    cx(1, 0, 0, 0, 2'h0, 2'h0, 8'hff);
    for (int i = 0; i < 7; i++) begin
      u_part.ev(ks[i], 32'h0);
      #1 chk("use_pend", use_pend_q, 1);
      rdc("use_stat", `PFH_USAGE_ERROR_STATUS, 32'h1 << bs[i]);
      bus(1'b1, `PFH_USAGE_ERROR_STATUS, 32'hffff_ffff);
    end
    u_part.ev(16'h8000, 32'hffff_fff9);
    #1 chk("ret_ok", use_pend_q, 0);
    cx(1, 0, 0, 0, 2'h3, 2'h0, 8'hff);
    u_part.ev(16'h0200, 32'h0);
    #1 chk("same_kind", top_pend_q, 1);
    cx(1, 0, 0, 0, 2'h0, 2'h0, 8'h03);
    u_part.ev(16'h1000, 32'h0);
    #1 chk("eq_prio", top_pend_q, 1);
    rdc("escalation_flag", `PFH_TOP_FAULT_STATUS, 32'h4000_0000);
  endtask
  task automatic s_lock;
    cx(0, 0, 1, 0, 2'h0, 2'h0, 8'hff);
    u_part.ev(16'h0001, 32'h4000_0000);
    #1 chk("top_lock", lockup_q, 1);
    @(posedge clk) debug_halt <= 1'b1;
    @(posedge clk) debug_halt <= 1'b0;
    #1 chk("dbg_exit", lockup_q, 0);
    u_part.ev(16'h0040, 32'h4000_0004);
    @(posedge clk) nmi_req <= 1'b1;
    @(posedge clk) nmi_req <= 1'b0;
    #1 chk("nmi_exit", lockup_q, 0);
    cx(0, 1, 0, 0, 2'h0, 2'h0, 8'hff);
    u_part.ev(16'h0040, 32'h4000_0008);
    @(posedge clk) nmi_req <= 1'b1;
    @(posedge clk) nmi_req <= 1'b0;
    #1 chk("nmi_stay", lockup_q, 1);
    rdc("state", `PFH_CORE_STATE, 32'h0000_0003);
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    #1 chk("rst_exit", lockup_q, 0);
    rdc("rst_top", `PFH_TOP_FAULT_STATUS, 32'h0);
    rdc("rst_state", `PFH_CORE_STATE, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    s_regs;
    s_bus;
    s_top;
    s_prot;
    s_use;
    s_lock;
    final_report;
  end
  initial begin
    #2000000;
    n_fail++;
    final_report;
  end
endmodule // tb_top
`default_nettype wire
